//--- src/ccanf_pkg.sv
// Purpose: constants and types shared by the car call anti nuisance filter
// Assumes: one 125 MHz clock, registers reached over AXI4-Lite with 32-bit data
// Notes: register offsets are byte addresses
// Operation
// R1: a new car call is refused while the accepted count is at or above the set maximum (0..63).
// R2: all car calls are erased after the set number of stops (1..63, 0 turns this off) pass without a photocell trigger.
// R3: with empty-car blocking on and the empty-car contact active, no car call is accepted.
// R4: with direction clearing on, car calls opposite the new travel direction are erased on a reversal.
// R5: with clear-both-directions on, both landing calls of the destination floor are erased on approach.
// R6: the stop count restarts at zero on a photocell trigger and after the car calls are cleared.
package ccanf_pkg;
	localparam int CCANF_FLOORS = 16;
	localparam int CCANF_CNT_W = 6;
	localparam logic [7:0] CCANF_CTRL_OFS = 8'h00;
	localparam logic [7:0] CCANF_LIMIT_OFS = 8'h04;
	localparam logic [7:0] CCANF_STATUS_OFS = 8'h08;
	localparam logic [7:0] CCANF_CAR_OFS = 8'h0c;
	localparam logic [7:0] CCANF_HALL_OFS = 8'h10;
	localparam int CCANF_EN_EMPTY_BIT = 0;
	localparam int CCANF_EN_DIR_BIT = 1;
	localparam int CCANF_EN_BOTH_BIT = 2;
	localparam int CCANF_MAXC_LSB = 0;
	localparam int CCANF_STOPS_LSB = 8;
	localparam logic [2:0] CCANF_CTRL_RST = 3'h0;
	localparam logic [5:0] CCANF_MAXC_RST = 6'h3f;
	localparam logic [5:0] CCANF_STOPS_RST = 6'h00;
	localparam logic [1:0] CCANF_RESP_OKAY = 2'h0;
	localparam logic [1:0] CCANF_RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {CCANF_DIR_NONE, CCANF_DIR_UP, CCANF_DIR_DOWN} ccanf_dir_e;
endpackage

//--- src/ccanf_axil.sv
// Purpose: AXI4-Lite slave for the filter's registers
// Assumes: single outstanding write and read, 32-bit data
// Notes: unmapped addresses answer SLVERR, reads of them give zero
`timescale 1ns/1ps
`default_nettype none
module ccanf_axil (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic wr_en,
	output logic [7:0] wr_addr,
	output logic [31:0] wr_data,
	output logic [3:0] wr_strb,
	output logic [7:0] rd_addr,
	input wire logic [31:0] rd_data,
	input wire logic rd_hit,
	input wire logic wr_hit
);
	import ccanf_pkg::*;

	typedef struct packed {
		logic aw_got;
		logic w_got;
		logic [7:0] aw_addr;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic awready;
		logic wready;
		logic arready;
	} ccanf_axs_s;

	ccanf_axs_s st_r;
	ccanf_axs_s st_nxt;

	// every bus output leaves the state register
	assign s_axi_awready = st_r.awready;
	assign s_axi_wready = st_r.wready;
	assign s_axi_arready = st_r.arready;
	assign s_axi_bvalid = st_r.bvalid;
	assign s_axi_bresp = st_r.bresp;
	assign s_axi_rvalid = st_r.rvalid;
	assign s_axi_rdata = st_r.rdata;
	assign s_axi_rresp = st_r.rresp;
	assign wr_en = st_r.aw_got && st_r.w_got;
	assign wr_addr = st_r.aw_addr;
	assign wr_data = st_r.w_data;
	assign wr_strb = st_r.w_strb;
	assign rd_addr = s_axi_araddr;

	// capture address and data in any order, answer once both are held
	always_comb
	begin
		st_nxt = st_r;
		if (s_axi_awvalid && s_axi_awready)
		begin
			st_nxt.aw_got = 1'b1;
			st_nxt.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			st_nxt.w_got = 1'b1;
			st_nxt.w_data = s_axi_wdata;
			st_nxt.w_strb = s_axi_wstrb;
		end
		if (st_r.aw_got && st_r.w_got)
		begin
			st_nxt.aw_got = 1'b0;
			st_nxt.w_got = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp = wr_hit ? CCANF_RESP_OKAY : CCANF_RESP_SLVERR;
		end
		if (st_r.bvalid && s_axi_bready)
			st_nxt.bvalid = 1'b0;
		if (s_axi_arvalid && s_axi_arready)
		begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rdata = rd_hit ? rd_data : 32'h0;
			st_nxt.rresp = rd_hit ? CCANF_RESP_OKAY : CCANF_RESP_SLVERR;
		end
		else if (st_r.rvalid && s_axi_rready)
			st_nxt.rvalid = 1'b0;
		// ready while the holding slot is empty and no answer is pending
		st_nxt.awready = !st_nxt.aw_got && !st_nxt.bvalid;
		st_nxt.wready = !st_nxt.w_got && !st_nxt.bvalid;
		st_nxt.arready = !st_nxt.rvalid;
	end

	// state register
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			st_r <= '0;
			st_r.awready <= 1'b1;
			st_r.wready <= 1'b1;
			st_r.arready <= 1'b1;
		end
		else
			st_r <= st_nxt;
	end
endmodule
`default_nettype wire

//--- src/ccanf_top.sv
// Purpose: car call anti nuisance filter for a lift controller
// Assumes: inputs synchronous to clk; call buttons are one-cycle pulses
// Notes: car calls and landing calls are one bit per floor
//
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module ccanf_top #(
	parameter int FLOORS = ccanf_pkg::CCANF_FLOORS
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [FLOORS-1:0] car_button,
	input wire logic [FLOORS-1:0] car_served,
	input wire logic [FLOORS-1:0] hall_up_button,
	input wire logic [FLOORS-1:0] hall_dn_button,
	input wire logic [FLOORS-1:0] hall_up_served,
	input wire logic [FLOORS-1:0] hall_dn_served,
	input wire logic [FLOORS-1:0] car_position,
	input wire logic travel_up,
	input wire logic travel_down,
	input wire logic stop_done,
	input wire logic photocell_trip,
	input wire logic empty_car_contact,
	input wire logic approach_pulse,
	input wire logic [FLOORS-1:0] approach_floor,
	output logic [FLOORS-1:0] car_calls,
	output logic [FLOORS-1:0] hall_up_calls,
	output logic [FLOORS-1:0] hall_dn_calls
);
	import ccanf_pkg::*;

	typedef struct packed {
		logic [2:0] ctrl;
		logic [CCANF_CNT_W-1:0] max_calls;
		logic [CCANF_CNT_W-1:0] stops_limit;
		logic [CCANF_CNT_W-1:0] stop_cnt;
		ccanf_dir_e dir;
		logic [FLOORS-1:0] car;
		logic [FLOORS-1:0] hup;
		logic [FLOORS-1:0] hdn;
		logic refused;
		logic cleared_stops;
	} ccanf_st_s;

	ccanf_st_s st_r;
	ccanf_st_s st_nxt;
	logic wr_en;
	logic [7:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic [7:0] rd_addr;
	logic [31:0] rd_data;
	logic rd_hit;
	logic wr_hit;

	// count of set bits in a call vector
	function automatic logic [7:0] ccanf_popcnt(input logic [FLOORS-1:0] v);
		logic [7:0] n;
		n = 8'h0;
		for (int i = 0; i < FLOORS; i++)
			n = n + {7'h0, v[i]};
		return n;
	endfunction

	// mask of floors strictly above (up) or below (down) the car
	function automatic logic [FLOORS-1:0] ccanf_side(input logic [FLOORS-1:0] pos, input logic above);
		logic [FLOORS-1:0] m;
		logic seen;
		m = '0;
		seen = 1'b0;
		for (int i = 0; i < FLOORS; i++)
		begin
			m[i] = seen;
			seen = seen | pos[i];
		end
		if (!above)
			m = ~(m | pos);
		return m;
	endfunction

	ccanf_axil u_axil (
		.clk(clk),
		.resetn(resetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.rd_hit(rd_hit),
		.wr_hit(wr_hit)
	);

	// address decode
	assign wr_hit = (wr_addr == CCANF_CTRL_OFS) || (wr_addr == CCANF_LIMIT_OFS);
	always_comb
	begin
		rd_hit = 1'b1;
		rd_data = 32'h0;
		case (rd_addr)
			CCANF_CTRL_OFS: rd_data = {29'h0, st_r.ctrl};
			CCANF_LIMIT_OFS: rd_data = {18'h0, st_r.stops_limit, 2'h0, st_r.max_calls};
			CCANF_STATUS_OFS: rd_data = {16'h0, 6'h0, st_r.cleared_stops, st_r.refused,
				st_r.dir, st_r.stop_cnt};
			CCANF_CAR_OFS: rd_data = 32'(st_r.car);
			CCANF_HALL_OFS: rd_data = {16'(st_r.hdn), 16'(st_r.hup)};
			default: rd_hit = 1'b0;
		endcase
	end

	assign car_calls = st_r.car;
	assign hall_up_calls = st_r.hup;
	assign hall_dn_calls = st_r.hdn;

	// call filtering and clearing
	always_comb
	begin
		logic [FLOORS-1:0] newc;
		logic [7:0] cnt;
		logic block;
		logic reverse;
		ccanf_dir_e dnew;
		newc = '0;
		cnt = 8'h0;
		block = 1'b0;
		reverse = 1'b0;
		dnew = st_r.dir;
		st_nxt = st_r;
		st_nxt.refused = 1'b0;
		st_nxt.cleared_stops = 1'b0;
		// software writes to control and limits
		if (wr_en && wr_addr == CCANF_CTRL_OFS && wr_strb[0])
			st_nxt.ctrl = wr_data[2:0];
		if (wr_en && wr_addr == CCANF_LIMIT_OFS && wr_strb[0])
			st_nxt.max_calls = wr_data[CCANF_MAXC_LSB +: CCANF_CNT_W];
		if (wr_en && wr_addr == CCANF_LIMIT_OFS && wr_strb[1])
			st_nxt.stops_limit = wr_data[CCANF_STOPS_LSB +: CCANF_CNT_W];
		// served calls drop out
		st_nxt.car = st_r.car & ~car_served;
		st_nxt.hup = (st_r.hup & ~hall_up_served) | hall_up_button;
		st_nxt.hdn = (st_r.hdn & ~hall_dn_served) | hall_dn_button;
		// accept new car calls one floor at a time against the limit
		cnt = ccanf_popcnt(st_nxt.car);
		block = st_r.ctrl[CCANF_EN_EMPTY_BIT] && empty_car_contact; // R3
		for (int i = 0; i < FLOORS; i++)
		begin
			if (car_button[i] && !st_nxt.car[i])
			begin
				if (block || cnt >= {2'h0, st_r.max_calls}) // R1
					st_nxt.refused = 1'b1;
				else
				begin
					newc[i] = 1'b1;
					cnt = cnt + 8'h1;
				end
			end
		end
		st_nxt.car = st_nxt.car | newc;
		// travel direction tracking and reversal clearing
		if (travel_up)
			dnew = CCANF_DIR_UP;
		else if (travel_down)
			dnew = CCANF_DIR_DOWN;
		reverse = (st_r.dir == CCANF_DIR_UP && dnew == CCANF_DIR_DOWN) ||
			(st_r.dir == CCANF_DIR_DOWN && dnew == CCANF_DIR_UP);
		st_nxt.dir = dnew;
		if (reverse && st_r.ctrl[CCANF_EN_DIR_BIT]) // R4
			st_nxt.car = st_nxt.car & ~ccanf_side(car_position, dnew == CCANF_DIR_DOWN);
		// approach clears both landing directions of the destination
		if (approach_pulse && st_r.ctrl[CCANF_EN_BOTH_BIT])
		begin
			st_nxt.hup = st_nxt.hup & ~approach_floor; // R5
			st_nxt.hdn = st_nxt.hdn & ~approach_floor; // R5
		end
		// stops without photocell trigger
		if (photocell_trip)
			st_nxt.stop_cnt = '0; // R6
		else if (stop_done)
		begin
			if ({1'b0, st_r.stop_cnt} + 7'h01 >= {1'b0, st_r.stops_limit} && st_r.stops_limit != 6'h0)
			begin
				st_nxt.car = '0; // R2
				st_nxt.stop_cnt = '0; // R6
				st_nxt.cleared_stops = 1'b1;
			end
			else
				st_nxt.stop_cnt = st_r.stop_cnt + 6'h1;
		end
	end

	// state register
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			st_r <= '0;
			st_r.ctrl <= CCANF_CTRL_RST;
			st_r.max_calls <= CCANF_MAXC_RST;
			st_r.stops_limit <= CCANF_STOPS_RST;
			st_r.dir <= CCANF_DIR_NONE;
		end
		else
			st_r <= st_nxt;
	end
endmodule
`default_nettype wire

//--- test/ccanf_panel.sv
// Purpose: car operating panel seen by the filter
// Assumes: one press request per cycle
// Notes: each request becomes one button pulse a cycle later
`timescale 1ns/1ps
`default_nettype none
module ccanf_panel #(
	parameter int FLOORS = ccanf_pkg::CCANF_FLOORS
) (
	input wire logic clk,
	input wire logic [FLOORS-1:0] press,
	output var logic [FLOORS-1:0] car_button = '0
);
	// contacts close for exactly one clock
	always @(posedge clk)
		car_button <= press;
endmodule
`default_nettype wire

//--- test/ccanf_monitor.sv
// Purpose: port checks for the car call filter
// Assumes: write address and data taken together
// Notes: settings copied from snooped writes
`timescale 1ns/1ps
`default_nettype none
module ccanf_monitor #(
	parameter int FLOORS = ccanf_pkg::CCANF_FLOORS
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [FLOORS-1:0] car_calls,
	input wire logic [FLOORS-1:0] hall_up_calls,
	input wire logic [FLOORS-1:0] hall_dn_calls,
	input wire logic [FLOORS-1:0] car_position,
	input wire logic [FLOORS-1:0] car_served,
	input wire logic [FLOORS-1:0] approach_floor,
	input wire logic travel_up,
	input wire logic travel_down,
	input wire logic stop_done,
	input wire logic photocell_trip,
	input wire logic empty_car_contact,
	input wire logic approach_pulse
);
	import ccanf_pkg::*;
	logic [31:0] ctl_r, lim_r;
	logic [5:0] cnt_r;
	logic wr, last;
	// write seen, and the stop that ends a run
	assign wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	assign last = stop_done && !photocell_trip && lim_r[13:8] != 6'h00 && {1'b0, cnt_r} + 7'h01 >= {1'b0, lim_r[13:8]};
	// settings copies and stop counter
	always_ff @(posedge clk or negedge resetn)
		if (!resetn) ctl_r <= 32'h0;
		else if (wr && s_axi_awaddr == CCANF_CTRL_OFS) ctl_r <= s_axi_wdata;
	always_ff @(posedge clk or negedge resetn)
		if (!resetn) lim_r <= 32'h3f;
		else if (wr && s_axi_awaddr == CCANF_LIMIT_OFS) lim_r <= s_axi_wdata;
	always_ff @(posedge clk or negedge resetn)
		if (!resetn) cnt_r <= 6'h00;
		else if (photocell_trip || last) cnt_r <= 6'h00;
		else if (stop_done) cnt_r <= cnt_r + 6'h01;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// direction reversals
	sequence s_to_dn;
		ctl_r[1] && $past(travel_up) && !travel_up && travel_down;
	endsequence
	sequence s_to_up;
		ctl_r[1] && !$past(travel_up) && $past(travel_down) && travel_up;
	endsequence
	property p_max;
		$countones(car_calls) >= lim_r[5:0] |=> $countones(car_calls) <= $countones($past(car_calls));
	endproperty
	a_max: assert property (p_max) else $error("car calls grew past the maximum");
	property p_empty;
		ctl_r[0] && empty_car_contact |=> (car_calls & ~$past(car_calls)) == '0;
	endproperty
	a_empty: assert property (p_empty) else $error("car call taken with empty car");
	property p_stops;
		last |=> car_calls == '0;
	endproperty
	a_stops: assert property (p_stops) else $error("car calls kept after stop limit");
	property p_rev_dn;
		s_to_dn |=> ((car_calls & ~(car_position | (car_position - 1'b1))) == '0) &&
			($past(stop_done) || (($past(car_calls) & ~$past(car_served) &
			(car_position | (car_position - 1'b1)) & ~car_calls) == '0));
	endproperty
	a_rev_dn: assert property (p_rev_dn) else $error("calls above car kept on turn down");
	property p_rev_up;
		s_to_up |=> ((car_calls & (car_position - 1'b1)) == '0) &&
			($past(stop_done) || (($past(car_calls) & ~$past(car_served) &
			~(car_position - 1'b1) & ~car_calls) == '0));
	endproperty
	a_rev_up: assert property (p_rev_up) else $error("calls below car kept on turn up");
	property p_both;
		ctl_r[2] && approach_pulse |=> ((hall_up_calls | hall_dn_calls) & $past(approach_floor)) == '0;
	endproperty
	a_both: assert property (p_both) else $error("landing call kept on approach");
endmodule
bind ccanf_top ccanf_monitor #(.FLOORS(FLOORS)) u_mon (.*);
`default_nettype wire

//--- test/ccanf_top_tb.sv
// Purpose: self-checking bench for the car call filter
// Assumes: sixteen floors, car parked at floor 5
// Notes: every result is read back over the register bus
`timescale 1ns/1ps
`default_nettype none
module ccanf_top_tb;
	import ccanf_pkg::*;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [15:0] press = 16'h0, car_served = 16'h0, hall_b = 16'h0, approach_floor = 16'h0, car_position = 16'h0020;
	logic [15:0] car_button, car_calls, hall_up_calls, hall_dn_calls, m, e1;
	logic travel_up = 1'b1, travel_down = 1'b0, stop_done = 1'b0, photocell_trip = 1'b0;
	logic empty_car_contact = 1'b0, approach_pulse = 1'b0;
	logic [33:0] exp_q[$];
	int fails = 0, samples_checked = 0;
	int mx[3] = '{0, 3, 63};
	always #4 clk = ~clk;
	ccanf_top uut (.*, .s_axi_wstrb(4'hf), .hall_up_button(hall_b), .hall_dn_button(hall_b),
		.hall_up_served(16'h0), .hall_dn_served(16'h0));
	ccanf_panel pnl (.*);
	task automatic conclude();
		if (fails == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [33:0] e, input logic [33:0] g);
		samples_checked++;
		if (g !== e)
		begin
			fails++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	// oldest note against each bus answer
	always @(negedge clk)
		if (s_axi_bvalid && s_axi_bready) chk(exp_q.pop_front(), {s_axi_bresp, 32'h0});
		else if (s_axi_rvalid && s_axi_rready) chk(exp_q.pop_front(), {s_axi_rresp, s_axi_rdata});
	// one bus access, each channel released when taken
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [33:0] e);
		logic ta, tw, tr, tb;
		exp_q.push_back(e);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= w;
		s_axi_wvalid <= w;
		s_axi_bready <= w;
		s_axi_arvalid <= !w;
		s_axi_rready <= !w;
		do
		begin
			@(negedge clk);
			ta = s_axi_awready;
			tw = s_axi_wready;
			tr = s_axi_arready;
			tb = s_axi_bvalid || s_axi_rvalid;
			@(posedge clk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			if (tr) s_axi_arvalid <= 1'b0;
			if (tb) s_axi_bready <= 1'b0;
			if (tb) s_axi_rready <= 1'b0;
		end while (!tb);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		acc(1'b1, a, d, {CCANF_RESP_OKAY, 32'h0});
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		acc(1'b0, a, 32'h0, {CCANF_RESP_OKAY, e});
	endtask
	// one-cycle pulses: press, served, landing, {approach, photocell, stop}; approach floor is held until the next call
	task automatic go(input logic [15:0] p, s, h, a, input logic [2:0] k);
		@(posedge clk);
		press <= p;
		car_served <= s;
		hall_b <= h;
		approach_floor <= a;
		{approach_pulse, photocell_trip, stop_done} <= k;
		@(posedge clk);
		press <= 16'h0;
		car_served <= 16'h0;
		hall_b <= 16'h0;
		{approach_pulse, photocell_trip, stop_done} <= 3'h0;
	endtask
	function automatic logic [15:0] low(input logic [15:0] v, input int n);
		low = 16'h0;
		for (int i = 0; i < 16; i++)
			if (v[i] && $countones(low) < n) low[i] = 1'b1;
	endfunction
	initial
	begin
		void'($urandom(32'h9ceaeec8));
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		rd(CCANF_LIMIT_OFS, 32'h3f);
		acc(1'b1, 8'h14, 32'h1, {CCANF_RESP_SLVERR, 32'h0});
		acc(1'b0, 8'h14, 32'h0, {CCANF_RESP_SLVERR, 32'h0});
		acc(1'b1, CCANF_CAR_OFS, 32'h1, {CCANF_RESP_SLVERR, 32'h0});
		// maximum at zero, small and full
		foreach (mx[i])
		begin
			m = (16'($urandom) | 16'h00c3) & 16'hffdf;
			e1 = low(m, mx[i]);
			wr(CCANF_LIMIT_OFS, 32'(mx[i]));
			go(m, 16'h0, 16'h0, 16'h0, 3'h0);
			rd(CCANF_CAR_OFS, {16'h0, e1});
			go(~m & 16'hffdf, 16'h0, 16'h0, 16'h0, 3'h0);
			rd(CCANF_CAR_OFS, {16'h0, e1 | low(~m & 16'hffdf, mx[i] - $countones(e1))});
			go(16'h0, 16'hffff, 16'h0, 16'h0, 3'h0);
		end
		// blocking option against empty contact
		for (int c = 0; c < 4; c++)
		begin
			wr(CCANF_CTRL_OFS, 32'(c[0]));
			empty_car_contact <= c[1];
			go(m, 16'h0, 16'h0, 16'h0, 3'h0);
			rd(CCANF_CAR_OFS, (c == 3) ? 32'h0 : {16'h0, m});
			go(16'h0, 16'hffff, 16'h0, 16'h0, 3'h0);
		end
		empty_car_contact <= 1'b0;
		// three stops without exit, photocell restarts the run
		wr(CCANF_LIMIT_OFS, 32'h033f);
		go(m, 16'h0, 16'h0, 16'h0, 3'h2);
		repeat (2) go(16'h0, 16'h0, 16'h0, 16'h0, 3'h1);
		go(16'h0, 16'h0, 16'h0, 16'h0, 3'h3);
		repeat (2) go(16'h0, 16'h0, 16'h0, 16'h0, 3'h1);
		rd(CCANF_CAR_OFS, {16'h0, m});
		go(16'h0, 16'h0, 16'h0, 16'h0, 3'h1);
		rd(CCANF_CAR_OFS, 32'h0);
		go(m, 16'h0, 16'h0, 16'h0, 3'h0);
		repeat (2) go(16'h0, 16'h0, 16'h0, 16'h0, 3'h1);
		rd(CCANF_CAR_OFS, {16'h0, m});
		go(16'h0, 16'hffff, 16'h0, 16'h0, 3'h0);
		// reversals around floor 5
		wr(CCANF_CTRL_OFS, 32'h2);
		go(m, 16'h0, 16'h0, 16'h0, 3'h0);
		{travel_up, travel_down} <= 2'b01;
		rd(CCANF_CAR_OFS, {16'h0, m & 16'h003f});
		go(m, 16'h0, 16'h0, 16'h0, 3'h0);
		{travel_up, travel_down} <= 2'b10;
		rd(CCANF_CAR_OFS, {16'h0, m & 16'hffe0});
		// both landing calls erased on approach
		wr(CCANF_CTRL_OFS, 32'h4);
		m = (16'($urandom) | 16'h0080) & 16'hffdf;
		go(16'h0, 16'h0, m, 16'h0, 3'h0);
		go(16'h0, 16'h0, 16'h0, 16'h0080, 3'h4);
		rd(CCANF_HALL_OFS, {2{m & 16'hff7f}});
		conclude();
	end
	initial
	begin
		#160000;
		fails++;
		conclude();
	end
endmodule
`default_nettype wire
